// >>> core/control_port_defines.vh
// Summary of operation
// (RQ1) Strap high selects SPI, low selects I2C
// (RQ2) Host keeps the protocol strap fixed
// (RQ3) I2C answers only address 0011000
// (RQ4) SDA is only pulled low or released
// (RQ5) Slave only: never drives clock or conditions
// (RQ6) Bits move while SCL low, eight per unit
// (RQ7) SDA edges while SCL high mark START/STOP
// (RQ8) Master sends address plus direction after START
// (RQ9) Device acknowledges each received byte on ninth clock
// (RQ10) Released SDA in acknowledge slot means not-acknowledge
// (RQ11) START during transfer restarts address decoding
// (RQ12) General call acknowledged only when enabled
// (RQ13) I2C write auto-increments register address
// (RQ14) Acknowledged I2C read sends next register
// (RQ15) SPI clock idles low, four pin port
// (RQ16) SPI phase 1: drive on first clock edge
// (RQ17) First SPI byte is command, second data on write
// (RQ18) Command bits 7..1 address, bit 0 read flag
// (RQ19) Host sends write with flag 0 and data
// (RQ20) SPI read shifts register out in second byte
// (RQ21) SPI shifts in and out at once
// (RQ22) Host writes reserved bits with their defaults
// (RQ23) Shared pins free for audio only in I2C
// (RQ24) Pin inputs synchronised and edge-detected first
`ifndef CONTROL_PORT_DEFINES_VH
`define CONTROL_PORT_DEFINES_VH

// Bus addresses
`define I2C_SLAVE_ADDR 7'h18
`define I2C_GCALL_BYTE 8'h00

// I2C engine states
`define I_IDLE 3'h0
`define I_ADDR 3'h1
`define I_ACK 3'h2
`define I_WRX 3'h3
`define I_TX 3'h4
`define I_RACK 3'h5

// Bit counts
`define I2C_BYTE_BITS 4'h8
`define SPI_CMD_LAST 5'h07
`define SPI_DATA_LAST 5'h0F
`define SPI_FRAME_BITS 5'h10

// Read data wait: reg_rdata_i is sampled this many edges after the request
`define RD_WAIT_START 2'h3

// Edges after reset release before the strap synchroniser shows the pin
`define STRAP_SETTLE 2'h2

// Reset values
`define RESET_BYTE 8'h00

`endif

// >>> core/pin_sync.v
`timescale 1ns/1ns
// Two-stage synchroniser with edge detection on the settled copy
module pin_sync #(
   parameter IDLE_LEVEL = 1'b1
) (
   input wire clock_i,
   input wire rst_n_i,
   input wire pin_i,
   output wire level_o,
   output wire rise_o,
   output wire fall_o
);

   reg meta_reg;
   reg sync_reg;
   reg last_reg;

   // First stage feeds only the second; edges look at stages two and three
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_reg <= IDLE_LEVEL;
         sync_reg <= IDLE_LEVEL;
         last_reg <= IDLE_LEVEL;
      end else begin
         meta_reg <= pin_i;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign level_o = sync_reg;
   assign rise_o = sync_reg & ~last_reg;
   assign fall_o = ~sync_reg & last_reg;

endmodule

// >>> core/dual_protocol_control_port.v
`timescale 1ns/1ns
`include "control_port_defines.vh"

// Serial control port: I2C slave or SPI slave onto an 8-bit register space
module dual_protocol_control_port (
   input wire clock_i,
   input wire resetn_i,
   input wire spi_sel_i,
   input wire clock_or_select_pin_i,
   input wire sclk_i,
   input wire sda_mosi_i,
   output reg sda_o,
   output reg sda_oe_n_o,
   output reg miso_o,
   output reg miso_oe_n_o,
   input wire gc_enable_i,
   input wire [7:0] reg_rdata_i,
   output reg [7:0] reg_addr_o,
   output reg [7:0] reg_wdata_o,
   output reg reg_write_o,
   output reg reg_read_o,
   output reg spi_mode_o,
   output reg aux_pins_free_o
);

   // Reset release path
   reg rst_meta_reg;
   reg rst_n_reg;
   wire rst_n;

   // Synchronised pins
   wire strap_level;
   wire cs_level;
   wire cs_rise;
   wire cs_fall;
   wire sclk_rise;
   wire sclk_fall;
   wire sda_level;
   wire sda_rise;
   wire sda_fall;

   // Protocol choice
   reg [1:0] strap_wait_reg;
   reg mode_valid_reg;
   reg spi_mode_reg;
   wire i2c_en;
   wire spi_en;
   wire start_det;
   wire stop_det;

   // I2C engine
   reg [2:0] i_state_reg;
   reg [3:0] i_cnt_reg;
   reg [7:0] i_shift_reg;
   reg i_rw_reg;
   reg [7:0] i_ptr_reg;
   reg i_have_ptr_reg;
   reg i_ack_reg;
   reg i_drive_reg;
   reg i_wr_reg;
   reg i_rd_reg;
   reg [7:0] i_addr_reg;
   reg [7:0] i_wdata_reg;

   // SPI engine
   reg [4:0] s_cnt_reg;
   reg [7:0] s_in_reg;
   reg [7:0] s_out_reg;
   reg s_rw_reg;
   reg s_wr_reg;
   reg s_rd_reg;
   reg [7:0] s_addr_reg;
   reg [7:0] s_wdata_reg;

   // Shared read return
   reg [1:0] rd_wait_reg;
   reg [7:0] rd_hold_reg;
   reg rd_ready_reg;

   // Asynchronous assert, synchronous release of the reset
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   assign rst_n = rst_n_reg;

   // Every pin passes two flops before the engines look at it
   pin_sync #(.IDLE_LEVEL(1'b0)) u_strap_sync ( // RQ24
      .clock_i(clock_i),
      .rst_n_i(rst_n),
      .pin_i(spi_sel_i),
      .level_o(strap_level),
      .rise_o(),
      .fall_o()
   );

   pin_sync #(.IDLE_LEVEL(1'b1)) u_cs_sync ( // RQ24
      .clock_i(clock_i),
      .rst_n_i(rst_n),
      .pin_i(clock_or_select_pin_i),
      .level_o(cs_level),
      .rise_o(cs_rise),
      .fall_o(cs_fall)
   );

   pin_sync #(.IDLE_LEVEL(1'b0)) u_sclk_sync ( // RQ24
      .clock_i(clock_i),
      .rst_n_i(rst_n),
      .pin_i(sclk_i),
      .level_o(),
      .rise_o(sclk_rise),
      .fall_o(sclk_fall)
   );

   pin_sync #(.IDLE_LEVEL(1'b1)) u_sda_sync ( // RQ24
      .clock_i(clock_i),
      .rst_n_i(rst_n),
      .pin_i(sda_mosi_i),
      .level_o(sda_level),
      .rise_o(sda_rise),
      .fall_o(sda_fall)
   );

   // Strap is caught once after reset; later changes are ignored
   always @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         strap_wait_reg <= 2'h0;
         mode_valid_reg <= 1'b0;
         spi_mode_reg <= 1'b0;
      end else if (strap_wait_reg != `STRAP_SETTLE) begin
         // Sync stages still hold their reset level, not the pin
         strap_wait_reg <= strap_wait_reg + 2'h1;
      end else if (!mode_valid_reg) begin
         mode_valid_reg <= 1'b1;
         spi_mode_reg <= strap_level; // RQ1
      end
   end

   assign i2c_en = mode_valid_reg & ~spi_mode_reg;
   assign spi_en = mode_valid_reg & spi_mode_reg;

   // Same sync delay on both lines keeps the SCL-high test honest
   assign start_det = i2c_en & cs_level & sda_fall; // RQ7
   assign stop_det = i2c_en & cs_level & sda_rise; // RQ7

   // I2C slave engine; it only ever watches SCL, never drives it (RQ5)
   always @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         i_state_reg <= `I_IDLE;
         i_cnt_reg <= 4'h0;
         i_shift_reg <= `RESET_BYTE;
         i_rw_reg <= 1'b0;
         i_ptr_reg <= `RESET_BYTE;
         i_have_ptr_reg <= 1'b0;
         i_ack_reg <= 1'b0;
         i_drive_reg <= 1'b0;
         i_wr_reg <= 1'b0;
         i_rd_reg <= 1'b0;
         i_addr_reg <= `RESET_BYTE;
         i_wdata_reg <= `RESET_BYTE;
      end else begin
         i_wr_reg <= 1'b0;
         i_rd_reg <= 1'b0;
         if (!i2c_en) begin
            i_state_reg <= `I_IDLE;
            i_drive_reg <= 1'b0;
         end else if (start_det) begin
            // A START in any state restarts address decoding
            i_state_reg <= `I_ADDR; // RQ11
            i_cnt_reg <= 4'h0;
            i_drive_reg <= 1'b0;
         end else if (stop_det) begin
            i_state_reg <= `I_IDLE;
            i_drive_reg <= 1'b0;
         end else begin
            case (i_state_reg)
               `I_ADDR, `I_WRX: begin
                  if (cs_rise && i_cnt_reg != `I2C_BYTE_BITS) begin
                     // Sample on the high pulse, MSB first
                     i_shift_reg <= {i_shift_reg[6:0], sda_level}; // RQ6
                     i_cnt_reg <= i_cnt_reg + 4'h1;
                  end else if (cs_fall && i_cnt_reg == `I2C_BYTE_BITS) begin
                     if (i_state_reg == `I_ADDR) begin
                        if (i_shift_reg[7:1] == `I2C_SLAVE_ADDR || // RQ3
                            (i_shift_reg == `I2C_GCALL_BYTE &&
                             gc_enable_i)) begin // RQ12
                           i_drive_reg <= 1'b1; // RQ9
                           i_rw_reg <= i_shift_reg[0]; // RQ8
                           i_state_reg <= `I_ACK;
                           if (i_shift_reg[0]) begin
                              // Fetch the first byte during the ack
                              i_rd_reg <= 1'b1;
                              i_addr_reg <= i_ptr_reg;
                           end else begin
                              i_have_ptr_reg <= 1'b0;
                           end
                        end else begin
                           // Not ours: SDA stays released
                           i_state_reg <= `I_IDLE; // RQ10
                        end
                     end else begin
                        if (!i_have_ptr_reg) begin
                           i_ptr_reg <= i_shift_reg;
                           i_have_ptr_reg <= 1'b1;
                        end else begin
                           i_wr_reg <= 1'b1;
                           i_addr_reg <= i_ptr_reg;
                           i_wdata_reg <= i_shift_reg;
                           i_ptr_reg <= i_ptr_reg + 8'h01; // RQ13
                        end
                        i_drive_reg <= 1'b1; // RQ9
                        i_state_reg <= `I_ACK;
                     end
                  end
               end
               `I_ACK: begin
                  if (cs_fall) begin
                     if (i_rw_reg) begin
                        // First data bit goes out as the ack ends
                        i_drive_reg <= ~rd_hold_reg[7]; // RQ4
                        i_shift_reg <= {rd_hold_reg[6:0], 1'b0};
                        i_cnt_reg <= 4'h1;
                        i_state_reg <= `I_TX;
                     end else begin
                        i_drive_reg <= 1'b0;
                        i_cnt_reg <= 4'h0;
                        i_state_reg <= `I_WRX;
                     end
                  end
               end
               `I_TX: begin
                  if (cs_fall) begin
                     if (i_cnt_reg == `I2C_BYTE_BITS) begin
                        i_drive_reg <= 1'b0;
                        i_state_reg <= `I_RACK;
                     end else begin
                        // Change SDA only while SCL is low
                        i_drive_reg <= ~i_shift_reg[7]; // RQ6
                        i_shift_reg <= {i_shift_reg[6:0], 1'b0};
                        i_cnt_reg <= i_cnt_reg + 4'h1;
                     end
                  end
               end
               `I_RACK: begin
                  if (cs_rise) begin
                     i_ack_reg <= ~sda_level; // RQ10
                     if (!sda_level) begin
                        i_ptr_reg <= i_ptr_reg + 8'h01; // RQ14
                        i_rd_reg <= 1'b1;
                        i_addr_reg <= i_ptr_reg + 8'h01;
                     end
                  end else if (cs_fall) begin
                     if (i_ack_reg) begin
                        i_drive_reg <= ~rd_hold_reg[7]; // RQ14
                        i_shift_reg <= {rd_hold_reg[6:0], 1'b0};
                        i_cnt_reg <= 4'h1;
                        i_state_reg <= `I_TX;
                     end else begin
                        i_state_reg <= `I_IDLE;
                     end
                  end
               end
               default: begin
                  i_state_reg <= `I_IDLE;
                  i_drive_reg <= 1'b0;
               end
            endcase
         end
      end
   end

   // SPI slave engine, CPOL 0 / CPHA 1: drive on rise, sample on fall
   always @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         s_cnt_reg <= 5'h00;
         s_in_reg <= `RESET_BYTE;
         s_out_reg <= `RESET_BYTE;
         s_rw_reg <= 1'b0;
         s_wr_reg <= 1'b0;
         s_rd_reg <= 1'b0;
         s_addr_reg <= `RESET_BYTE;
         s_wdata_reg <= `RESET_BYTE;
         miso_o <= 1'b0;
      end else begin
         s_wr_reg <= 1'b0;
         s_rd_reg <= 1'b0;
         if (!spi_en || cs_fall) begin
            // Each select fall opens a new command byte
            s_cnt_reg <= 5'h00; // RQ17
            s_out_reg <= `RESET_BYTE;
            s_rw_reg <= 1'b0;
            miso_o <= 1'b0;
         end else if (!cs_level) begin
            if (rd_ready_reg && s_rw_reg) begin
               s_out_reg <= rd_hold_reg; // RQ20
            end else if (sclk_rise) begin
               // A bit leaves on every clock, command byte included
               miso_o <= s_out_reg[7]; // RQ16 RQ21
               s_out_reg <= {s_out_reg[6:0], 1'b0};
            end
            if (sclk_fall && s_cnt_reg != `SPI_FRAME_BITS) begin
               s_in_reg <= {s_in_reg[6:0], sda_level};
               s_cnt_reg <= s_cnt_reg + 5'h01;
               if (s_cnt_reg == `SPI_CMD_LAST) begin
                  s_addr_reg <= {1'b0, s_in_reg[6:0]}; // RQ18
                  s_rw_reg <= sda_level; // RQ18
                  s_rd_reg <= sda_level;
               end
               if (s_cnt_reg == `SPI_DATA_LAST && !s_rw_reg) begin
                  s_wr_reg <= 1'b1; // RQ17
                  s_wdata_reg <= {s_in_reg[6:0], sda_level};
               end
            end
         end
      end
   end

   // Register access and read-data return shared by both engines
   always @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         reg_addr_o <= `RESET_BYTE;
         reg_wdata_o <= `RESET_BYTE;
         reg_write_o <= 1'b0;
         reg_read_o <= 1'b0;
         rd_wait_reg <= 2'h0;
         rd_hold_reg <= `RESET_BYTE;
         rd_ready_reg <= 1'b0;
      end else begin
         reg_write_o <= i_wr_reg | s_wr_reg;
         reg_read_o <= i_rd_reg | s_rd_reg;
         if (i_wr_reg | i_rd_reg) begin
            reg_addr_o <= i_addr_reg;
            reg_wdata_o <= i_wdata_reg;
         end else if (s_wr_reg | s_rd_reg) begin
            reg_addr_o <= s_addr_reg;
            reg_wdata_o <= s_wdata_reg;
         end
         rd_ready_reg <= 1'b0;
         if (i_rd_reg | s_rd_reg) begin
            rd_wait_reg <= `RD_WAIT_START;
         end else if (rd_wait_reg != 2'h0) begin
            rd_wait_reg <= rd_wait_reg - 2'h1;
            if (rd_wait_reg == 2'h1) begin
               rd_hold_reg <= reg_rdata_i;
               rd_ready_reg <= 1'b1;
            end
         end
      end
   end

   // Pin drivers; MISO and SCLK are handed to audio only in I2C mode
   always @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         sda_o <= 1'b0;
         sda_oe_n_o <= 1'b1;
         miso_oe_n_o <= 1'b1;
         spi_mode_o <= 1'b0;
         aux_pins_free_o <= 1'b0;
      end else begin
         sda_o <= 1'b0; // RQ4
         sda_oe_n_o <= ~i_drive_reg; // RQ4
         miso_oe_n_o <= ~(spi_en & ~cs_level); // RQ15 RQ23
         spi_mode_o <= spi_en;
         aux_pins_free_o <= i2c_en; // RQ23
      end
   end

endmodule

// >>> testbench/control_port_checker.sv
`timescale 1ns/1ns
// Pin and strobe relations of the control port, watched from outside
module control_port_checker (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic spi_sel_i,
   input wire logic clock_or_select_pin_i,
   input wire logic sclk_i,
   input wire logic sda_mosi_i,
   input wire logic sda_o,
   input wire logic sda_oe_n_o,
   input wire logic miso_o,
   input wire logic miso_oe_n_o,
   input wire logic gc_enable_i,
   input wire logic [7:0] reg_rdata_i,
   input wire logic [7:0] reg_addr_o,
   input wire logic [7:0] reg_wdata_o,
   input wire logic reg_write_o,
   input wire logic reg_read_o,
   input wire logic spi_mode_o,
   input wire logic aux_pins_free_o
);
   // One clock domain, so one clocking and one disable for all
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!resetn_i);

   a_sda_pull_only: assert property (sda_o == 1'b0)
      else $error("SDA output not low");
   a_ack_i2c_only: assert property (!sda_oe_n_o |-> aux_pins_free_o)
      else $error("SDA pulled outside I2C mode");
   a_miso_spi_only: assert property (!miso_oe_n_o |-> spi_mode_o)
      else $error("MISO driven outside SPI mode");
   a_mode_onehot: assert property ((spi_mode_o || aux_pins_free_o)
      |-> spi_mode_o != aux_pins_free_o) else $error("Both modes");
   a_mode_held: assert property ((spi_mode_o || aux_pins_free_o)
      |=> $stable(spi_mode_o)) else $error("Mode changed");
   a_strap_follow: assert property (($rose(spi_mode_o)
      || $rose(aux_pins_free_o)) |-> spi_mode_o == spi_sel_i)
      else $error("Mode differs from strap");
   // Six idle cycles cover the pin synchroniser and output register
   a_miso_release: assert property (clock_or_select_pin_i [*6]
      |-> miso_oe_n_o) else $error("MISO held after deselect");
   a_no_idle_access: assert property ((spi_mode_o
      && clock_or_select_pin_i) [*8] |-> !reg_write_o && !reg_read_o)
      else $error("Access while deselected");
   a_write_pulse: assert property (reg_write_o |=> !reg_write_o)
      else $error("Write strobe longer than a cycle");
   a_read_pulse: assert property (reg_read_o |=> !reg_read_o)
      else $error("Read strobe longer than a cycle");
   // Device moves SDA only after SCL has gone low
   a_sda_still_high: assert property (clock_or_select_pin_i [*8]
      |-> $stable(sda_oe_n_o)) else $error("SDA moved with SCL high");
endmodule

bind dual_protocol_control_port control_port_checker
   control_port_checker_inst (.clock_i(clock_i), .resetn_i(resetn_i),
   .spi_sel_i(spi_sel_i), .clock_or_select_pin_i(clock_or_select_pin_i),
   .sclk_i(sclk_i), .sda_mosi_i(sda_mosi_i), .sda_o(sda_o),
   .sda_oe_n_o(sda_oe_n_o), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o),
   .gc_enable_i(gc_enable_i), .reg_rdata_i(reg_rdata_i),
   .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o),
   .reg_write_o(reg_write_o), .reg_read_o(reg_read_o),
   .spi_mode_o(spi_mode_o), .aux_pins_free_o(aux_pins_free_o));

// >>> testbench/host_model.sv
`timescale 1ns/1ns
// Host master for both control ports, paced in system clocks
module host_model (
   input wire logic clk_i,
   input wire logic sda_i,
   input wire logic miso_i,
   output logic scl_o,
   output logic sda_rel_o,
   output logic sclk_o,
   output logic mosi_o,
   output logic ss_n_o
);
   // Idle bus: I2C lines released high, SPI clock low
   initial begin
      scl_o = 1'b1;
      sda_rel_o = 1'b1;
      sclk_o = 1'b0;
      mosi_o = 1'b0;
      ss_n_o = 1'b1;
   end
   // Eight clocks a phase, above the six the port needs
   task automatic half();
      repeat (8) @(posedge clk_i);
   endtask
   // Also serves as repeated START when the bus is busy
   task automatic start();
      sda_rel_o <= 1'b1;
      half();
      scl_o <= 1'b1;
      half();
      sda_rel_o <= 1'b0;
      half();
      scl_o <= 1'b0;
      half();
   endtask
   task automatic stop();
      sda_rel_o <= 1'b0;
      half();
      scl_o <= 1'b1;
      half();
      sda_rel_o <= 1'b1;
      half();
   endtask
   // Data set while SCL low, sampled at the end of the high phase
   task automatic xbit(input logic b, output logic r);
      sda_rel_o <= b;
      half();
      scl_o <= 1'b1;
      half();
      r = sda_i;
      scl_o <= 1'b0;
      half();
   endtask
   // Eight bits MSB first, then the acknowledge slot
   task automatic xbyte(input logic [7:0] d, input logic m,
                        output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--) begin
         xbit(d[i], q[i]);
      end
      xbit(m, a);
   endtask
   // One 16-clock frame; MOSI set on each rise, MISO read before fall
   task automatic spi(input logic [15:0] d, output logic [15:0] q);
      ss_n_o <= 1'b0;
      half();
      for (int i = 15; i >= 0; i--) begin
         sclk_o <= 1'b1;
         mosi_o <= d[i];
         half();
         q[i] = miso_i;
         sclk_o <= 1'b0;
         half();
      end
      ss_n_o <= 1'b1;
      mosi_o <= ~mosi_o; // Released line must not keep the last bit
      half();
   endtask
endmodule

// >>> testbench/dual_protocol_control_port_bench.sv
`timescale 1ns/1ns
// Self-checking bench: I2C then SPI, register space modelled here
module dual_protocol_control_port_bench;
   logic clock_i;
   logic resetn_i;
   logic spi_sel;
   logic gc_en;
   logic [7:0] rdata;
   logic scl, sda_rel, sclk, mosi, ss_n;
   wire sda_o, sda_oe_n, miso, miso_oe_n, wr, rd, spi_mode, aux;
   wire [7:0] addr, wdata;
   int n_mismatch;
   int check_count;
   int rd_count;
   logic [15:0] wr_log[$];
   // Open-drain SDA with pull-up
   wire sda_line = sda_rel & (sda_oe_n | sda_o);

   dual_protocol_control_port dual_protocol_control_port_inst (
      .clock_i(clock_i), .resetn_i(resetn_i), .spi_sel_i(spi_sel),
      .clock_or_select_pin_i(spi_sel ? ss_n : scl), .sclk_i(sclk),
      .sda_mosi_i(spi_sel ? mosi : sda_line), .sda_o(sda_o),
      .sda_oe_n_o(sda_oe_n), .miso_o(miso), .miso_oe_n_o(miso_oe_n),
      .gc_enable_i(gc_en), .reg_rdata_i(rdata), .reg_addr_o(addr),
      .reg_wdata_o(wdata), .reg_write_o(wr), .reg_read_o(rd),
      .spi_mode_o(spi_mode), .aux_pins_free_o(aux));
   host_model host_model_inst (.clk_i(clock_i), .sda_i(sda_line),
      .miso_i(miso_oe_n ? ~miso : miso), .scl_o(scl), .sda_rel_o(sda_rel),
      .sclk_o(sclk), .mosi_o(mosi), .ss_n_o(ss_n));

   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   // Register space: read data is a pattern of the address
   always @(posedge clock_i) begin
      rdata <= addr ^ 8'h5A;
      if (wr === 1'b1) wr_log.push_back({addr, wdata});
      if (rd === 1'b1) rd_count++;
   end
   task automatic check(input string what, input logic [15:0] exp,
                        input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Strap changes only while reset is held
   task automatic do_reset(input logic sel);
      resetn_i <= 1'b0;
      spi_sel <= sel;
      repeat (2) @(posedge clock_i);
      resetn_i <= 1'b1;
      repeat (10) @(posedge clock_i);
      wr_log.delete();
      rd_count = 0;
   endtask
   // Send one byte from the master and judge the acknowledge
   task automatic send(input logic [7:0] d, input logic exp);
      logic [7:0] q;
      logic a;
      host_model_inst.xbyte(d, 1'b1, q, a);
      check("ack", {15'h0000, exp}, {15'h0000, a});
   endtask
   task automatic i2c_write_test();
      check("mode", 16'h0001, {spi_mode, aux});
      host_model_inst.start();
      send(8'h30, 1'b0);
      send(8'h10, 1'b0);
      send(8'hC3, 1'b0);
      send(8'h3C, 1'b0);
      host_model_inst.stop();
      check("writes", 16'h0002, wr_log.size());
      check("write 0", 16'h10C3, wr_log[0]);
      check("write 1", 16'h113C, wr_log[1]);
   endtask
   // Pointer set, then repeated START into a two-byte read
   task automatic i2c_read_test();
      logic [7:0] q;
      logic a;
      wr_log.delete();
      rd_count = 0;
      host_model_inst.start();
      send(8'h30, 1'b0);
      send(8'h20, 1'b0);
      host_model_inst.start();
      send(8'h31, 1'b0);
      host_model_inst.xbyte(8'hFF, 1'b0, q, a);
      check("read 0", 16'h007A, q);
      host_model_inst.xbyte(8'hFF, 1'b1, q, a);
      check("read 1", 16'h007B, q);
      host_model_inst.stop();
      check("no write", 16'h0000, wr_log.size());
      check("reads", 16'h0002, rd_count);
   endtask
   // Foreign address and general call with the enable off and on
   task automatic i2c_refuse_test();
      host_model_inst.start();
      send(8'h32, 1'b1);
      host_model_inst.stop();
      host_model_inst.start();
      send(8'h00, 1'b1);
      host_model_inst.stop();
      gc_en <= 1'b1;
      host_model_inst.start();
      send(8'h00, 1'b0);
      host_model_inst.stop();
      gc_en <= 1'b0;
   endtask
   task automatic spi_test();
      logic [15:0] q;
      do_reset(1'b1);
      check("mode", 16'h0002, {spi_mode, aux});
      host_model_inst.spi(16'hFEA5, q);
      check("spi write", 16'h7FA5, wr_log[0]);
      check("cmd miso", 16'h0000, q[15:8]);
      host_model_inst.spi(16'h0B00, q);
      check("spi read", 16'h005F, q[7:0]);
      check("writes", 16'h0001, wr_log.size());
      check("reads", 16'h0001, rd_count);
   endtask
   task automatic final_report();
      if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      resetn_i = 1'b0;
      spi_sel = 1'b0;
      gc_en = 1'b0;
      rdata = 8'h00;
      n_mismatch = 0;
      check_count = 0;
      rd_count = 0;
      do_reset(1'b0);
      i2c_write_test();
      i2c_read_test();
      i2c_refuse_test();
      spi_test();
      final_report();
   end
   // About 3500 cycles of traffic; nine times that means a hang
   initial begin
      repeat (32000) @(posedge clock_i);
      n_mismatch++;
      final_report();
   end
endmodule
